// [src/chd_top.sv]
// card host data path: resets, dma requests, card clock pause, suspend/resume
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module chd_top #(
    parameter int DATA_W = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic card_clk_in,
    input wire logic [DATA_W-1:0] card_data_in,
    output logic [DATA_W-1:0] card_data_out,
    output logic card_clk_stop_out,
    output logic dma_rx_req_out,
    output logic dma_tx_req_out,
    output logic [7:0] cmd_byte_out
);
    logic clk_s1, clk_s2, clk_s3;
    logic [DATA_W-1:0] din_s1, din_s2;
    logic soft_rst, card_clk_seen, power_on, int_rst;
    logic [15:0] control_reg, block_length_reg, block_count_reg;
    chd_pkg::chd_cmd_byte_t command;
    chd_pkg::chd_thresholds_t thr;
    logic suspend_flag, resume_flag, save_flag, stop_flag;
    logic [DATA_W-1:0] fifo_mem [chd_pkg::FIFO_DEPTH];
    logic [chd_pkg::FIFO_AW-1:0] wr_ptr, rd_ptr;
    logic [chd_pkg::FIFO_AW:0] level;
    logic [chd_pkg::FIFO_AW-1:0] burst_cnt;
    logic burst_mask, xfer_active;
    logic [15:0] word_in_block;
    logic card_edge, fifo_full, fifo_empty, card_push, card_pop, host_push, host_pop;
    logic acc, wr_acc, rd_acc, mapped, fifo_level_flag, is_write_dir;
    logic req_pending, block_end, rx_live;

    // two-flop synchronisers; third flop only for edge finding on the clean copy
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            din_s1 <= '0;
            din_s2 <= '0;
        end
        else
        begin
            clk_s1 <= card_clk_in;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            din_s1 <= card_data_in;
            din_s2 <= din_s1;
        end
    end
    assign card_edge = clk_s2 & ~clk_s3;

    assign acc = psel_in & penable_in;
    assign wr_acc = acc & pwrite_in;
    assign rd_acc = acc & ~pwrite_in;
    assign pready_out = 1'b1;
    always_comb
    begin
        unique case (paddr_in)
            chd_pkg::OFS_CONTROL, chd_pkg::OFS_COMMAND, chd_pkg::OFS_BUFFER,
            chd_pkg::OFS_BLOCK_LEN, chd_pkg::OFS_BLOCK_CNT, chd_pkg::OFS_DATA,
            chd_pkg::OFS_STATUS, chd_pkg::OFS_SUSPEND, chd_pkg::OFS_SYSCTL,
            chd_pkg::OFS_RST_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr_out = acc & ~mapped;

    // soft reset pulse acts for one cycle on everything below except fifo_mem, which no reset clears, and prdata_out, which only the hardware reset clears
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            soft_rst <= 1'b0;
        else
            soft_rst <= wr_acc && paddr_in == chd_pkg::OFS_SYSCTL
                && pwdata_in[chd_pkg::BIT_SOFT_RESET];
    end

    // clock presence is relearned after a hardware or soft reset; the power-bit reset keeps it
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            card_clk_seen <= 1'b0;
        else if (soft_rst)
            card_clk_seen <= 1'b0;
        else if (card_edge)
            card_clk_seen <= 1'b1;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            control_reg <= '0;
        else if (soft_rst)
            control_reg <= '0;
        else if (wr_acc && paddr_in == chd_pkg::OFS_CONTROL)
            control_reg <= pwdata_in[15:0];
    end
    assign power_on = control_reg[chd_pkg::BIT_POWER];
    assign int_rst = soft_rst | ~power_on;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            thr <= '0;
            block_length_reg <= '0;
            command <= '0;
        end
        else if (int_rst)
        begin
            thr <= '0;
            block_length_reg <= '0;
            command <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr_in == chd_pkg::OFS_BUFFER)
            begin
                thr.rx_threshold <= pwdata_in[chd_pkg::THR_W-1:0];
                thr.tx_threshold <= pwdata_in[chd_pkg::BUF_TX_LSB +: chd_pkg::THR_W];
            end
            if (paddr_in == chd_pkg::OFS_BLOCK_LEN)
                block_length_reg <= pwdata_in[15:0];
            if (paddr_in == chd_pkg::OFS_COMMAND)
                command <= pwdata_in[7:0];
        end
    end
    assign cmd_byte_out = command;
    assign is_write_dir = command.data_direction_bit;

    // suspend/resume control; stop clears itself once no request is outstanding
    assign req_pending = dma_rx_req_out | dma_tx_req_out;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            suspend_flag <= 1'b0;
            resume_flag <= 1'b0;
            save_flag <= 1'b0;
            stop_flag <= 1'b0;
        end
        else if (int_rst)
        begin
            suspend_flag <= 1'b0;
            resume_flag <= 1'b0;
            save_flag <= 1'b0;
            stop_flag <= 1'b0;
        end
        else if (wr_acc && paddr_in == chd_pkg::OFS_SUSPEND)
        begin
            suspend_flag <= pwdata_in[chd_pkg::BIT_SUSPEND];
            resume_flag <= pwdata_in[chd_pkg::BIT_RESUME];
            save_flag <= pwdata_in[chd_pkg::BIT_SAVE];
            stop_flag <= stop_flag | pwdata_in[chd_pkg::BIT_STOP];
        end
        else if (stop_flag && !req_pending)
            stop_flag <= 1'b0;
    end

    // block transfer: started by an addressed-with-data command, ended by the count
    assign block_end = card_push | card_pop
        ? (word_in_block + 16'h0001 >= block_length_reg) : 1'b0;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            xfer_active <= 1'b0;
            word_in_block <= '0;
            block_count_reg <= '0;
        end
        else if (int_rst)
        begin
            xfer_active <= 1'b0;
            word_in_block <= '0;
            block_count_reg <= '0;
        end
        else if (wr_acc && paddr_in == chd_pkg::OFS_BLOCK_CNT)
            block_count_reg <= pwdata_in[15:0];
        else if (wr_acc && paddr_in == chd_pkg::OFS_COMMAND)
        begin
            xfer_active <= pwdata_in[5:4] == chd_pkg::TYPE_ADTC
                && block_count_reg != 16'h0000;
            word_in_block <= '0;
        end
        else if (block_end)
        begin
            word_in_block <= '0;
            block_count_reg <= block_count_reg - 16'h0001;
            // a suspend only takes hold between blocks of a multi-block run
            if (block_count_reg == 16'h0001 || (suspend_flag && block_count_reg > 16'h0001))
                xfer_active <= 1'b0;
        end
        else if (card_push | card_pop)
            word_in_block <= word_in_block + 16'h0001;
    end

    // shared fifo: card fills it on reads, drains it on writes
    assign fifo_full = level == 6'(chd_pkg::FIFO_DEPTH);
    assign fifo_empty = level == '0;
    assign card_push = xfer_active && !is_write_dir && card_edge && !fifo_full;
    assign card_pop = xfer_active && is_write_dir && card_edge && !fifo_empty;
    assign host_push = wr_acc && paddr_in == chd_pkg::OFS_DATA && !fifo_full;
    assign host_pop = rd_acc && paddr_in == chd_pkg::OFS_DATA && !fifo_empty;
    assign rx_live = xfer_active || !fifo_empty; // words left after the block still drain
    assign card_clk_stop_out = xfer_active && (is_write_dir ? fifo_empty : fifo_full);

    always_ff @(posedge clk_in)
    begin
        if (card_push)
            fifo_mem[wr_ptr] <= din_s2;
        else if (host_push)
            fifo_mem[wr_ptr] <= pwdata_in[DATA_W-1:0];
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            card_data_out <= '0;
        end
        else if (int_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            card_data_out <= '0;
        end
        else
        begin
            if (card_push | host_push)
                wr_ptr <= wr_ptr + 1'b1;
            if (card_pop | host_pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (card_pop)
                card_data_out <= fifo_mem[rd_ptr];
            level <= level + 6'((card_push | host_push) ? 1 : 0)
                - 6'((card_pop | host_pop) ? 1 : 0);
        end
    end

    // dma requests: one word per request, masked for a burst of threshold+1 words
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            dma_rx_req_out <= 1'b0;
            dma_tx_req_out <= 1'b0;
            burst_mask <= 1'b0;
            burst_cnt <= '0;
        end
        else if (int_rst || (wr_acc && paddr_in == chd_pkg::OFS_COMMAND))
        begin
            dma_rx_req_out <= 1'b0;
            dma_tx_req_out <= 1'b0;
            burst_mask <= 1'b0;
            burst_cnt <= '0;
        end
        else
        begin
            if (host_pop || host_push)
                dma_rx_req_out <= 1'b0;
            else if (!burst_mask && !stop_flag && rx_live && !is_write_dir && !save_flag
                     && level >= {1'b0, thr.rx_threshold})
                dma_rx_req_out <= 1'b1;
            if (host_push || host_pop || !xfer_active)
                dma_tx_req_out <= 1'b0;
            else if (!burst_mask && !stop_flag && xfer_active && is_write_dir && !suspend_flag
                     && level <= {1'b0, thr.tx_threshold})
                dma_tx_req_out <= 1'b1;
            if (!burst_mask && (next_rx_set() || next_tx_set()))
            begin
                burst_mask <= 1'b1;
                burst_cnt <= '0;
            end
            else if (burst_mask && (is_write_dir ? host_push : host_pop))
            begin
                burst_cnt <= burst_cnt + 1'b1;
                if (burst_cnt == (is_write_dir ? thr.tx_threshold : thr.rx_threshold))
                    burst_mask <= 1'b0;
            end
        end
    end
    function automatic logic next_rx_set();
        return !dma_rx_req_out && !stop_flag && rx_live && !is_write_dir && !save_flag
            && level >= {1'b0, thr.rx_threshold} && !(host_pop || host_push);
    endfunction
    function automatic logic next_tx_set();
        return !dma_tx_req_out && !stop_flag && xfer_active && is_write_dir && !suspend_flag
            && level <= {1'b0, thr.tx_threshold} && !(host_push || host_pop);
    endfunction
    always_comb
    begin
        if (save_flag)
            fifo_level_flag = !fifo_empty;
        else if (is_write_dir)
            fifo_level_flag = level <= {1'b0, thr.tx_threshold};
        else
            fifo_level_flag = level >= {1'b0, thr.rx_threshold};
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            prdata_out <= '0;
        else if (psel_in && !penable_in && !pwrite_in)
        begin
            unique case (paddr_in)
                chd_pkg::OFS_CONTROL: prdata_out <= {16'h0000, control_reg};
                chd_pkg::OFS_COMMAND: prdata_out <= {24'h000000, command};
                chd_pkg::OFS_BUFFER: prdata_out <= {19'h00000, thr.tx_threshold,
                    3'h0, thr.rx_threshold};
                chd_pkg::OFS_BLOCK_LEN: prdata_out <= {16'h0000, block_length_reg};
                chd_pkg::OFS_BLOCK_CNT: prdata_out <= {16'h0000, block_count_reg};
                chd_pkg::OFS_DATA: prdata_out <= {16'h0000, fifo_mem[rd_ptr]};
                chd_pkg::OFS_STATUS: prdata_out <= {24'h000000, level, xfer_active,
                    fifo_level_flag};
                chd_pkg::OFS_SUSPEND: prdata_out <= {28'h0000000, stop_flag, save_flag,
                    resume_flag, suspend_flag};
                chd_pkg::OFS_SYSCTL: prdata_out <= 32'h00000000;
                chd_pkg::OFS_RST_STATUS: prdata_out <= {31'h00000000,
                    card_clk_seen & power_on & ~soft_rst};
                default: prdata_out <= 32'h00000000;
            endcase
        end
    end
endmodule

// [src/chd_pkg.sv]
// package: register map, field positions and types for the card host data-path block
// Functional notes
// - soft reset bit resets all, self-clears, reads zero
// - power bit gives partial reset
// - reset-done flag low during any reset
// - reset done only after card clock seen
// - rx request at level above threshold, drops per word
// - rx requests masked until n reads done
// - full rx fifo pauses card clock
// - tx request at level below threshold after command
// - tx requests masked until n writes done
// - empty tx fifo pauses card clock
// - suspend and resume only for multi-block transfers; suspend also blocks tx requests in single-block writes, resume does nothing
// - command byte field layout from top bit
// - command type and response index codes
// - save mode: level flag zero only when empty
package chd_pkg;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COMMAND = 8'h04;
    localparam logic [7:0] OFS_BUFFER = 8'h08;
    localparam logic [7:0] OFS_BLOCK_LEN = 8'h0C;
    localparam logic [7:0] OFS_BLOCK_CNT = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_SUSPEND = 8'h60;
    localparam logic [7:0] OFS_SYSCTL = 8'h64;
    localparam logic [7:0] OFS_RST_STATUS = 8'h68;
    localparam int BIT_SOFT_RESET = 1;
    localparam int BIT_POWER = 11;
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_RESUME = 1;
    localparam int BIT_SAVE = 2;
    localparam int BIT_STOP = 3;
    localparam int BUF_TX_LSB = 8;
    localparam int THR_W = 5;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;
    localparam logic [1:0] TYPE_BC = 2'h0;
    localparam logic [1:0] TYPE_BCR = 2'h1;
    localparam logic [1:0] TYPE_AC = 2'h2;
    localparam logic [1:0] TYPE_ADTC = 2'h3;
    localparam logic [2:0] RESP_NONE = 3'h0;
    localparam logic [7:0] CMD_AC_R1B = 8'h29;
    localparam logic [7:0] CMD_HOST_RESP = 8'h40;
    typedef struct packed {
        logic data_direction_bit;
        logic stream_or_host_reply_bit;
        logic [1:0] cmd_type;
        logic busy_expected;
        logic [2:0] resp_index;
    } chd_cmd_byte_t;
    typedef struct packed {
        logic [THR_W-1:0] tx_threshold;
        logic [THR_W-1:0] rx_threshold;
    } chd_thresholds_t;
endpackage

// [verification/chd_top_monitor.sv]
// port checker for the card host data path, bound into the top module
`timescale 1ns/1ns
module chd_top_monitor #(
    parameter int DATA_W = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic card_clk_in,
    input wire logic [DATA_W-1:0] card_data_in,
    input wire logic [DATA_W-1:0] card_data_out,
    input wire logic card_clk_stop_out,
    input wire logic dma_rx_req_out,
    input wire logic dma_tx_req_out,
    input wire logic [7:0] cmd_byte_out
);
    wire wr = psel_in && penable_in && pwrite_in;
    wire rd = psel_in && penable_in && !pwrite_in;
    logic pow_on;
    // power bit as software last left it; a soft reset clears it
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pow_on <= 1'b0;
        else if (wr && paddr_in == 8'h00)
            pow_on <= pwdata_in[11];
        else if (wr && paddr_in == 8'h64 && pwdata_in[1])
            pow_on <= 1'b0;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    property p_soft_reset_bit_zero;
        rd && paddr_in == 8'h64 |-> !prdata_out[1];
    endproperty
    a_soft_reset_bit_zero: assert property (p_soft_reset_bit_zero) else $error("soft reset bit reads one");
    property p_soft_reset_bit_clear;
        wr && paddr_in == 8'h64 && pwdata_in[1]
            |-> ##[1:3] (cmd_byte_out == 8'h00 && !dma_rx_req_out && !dma_tx_req_out);
    endproperty
    a_soft_reset_bit_clear: assert property (p_soft_reset_bit_clear) else $error("soft reset left state");
    property p_partial;
        rd && paddr_in == 8'h68 && !pow_on |-> !prdata_out[0];
    endproperty
    a_partial: assert property (p_partial) else $error("done while power off");
    property p_release;
        $fell(sys_rst_in) |-> !dma_rx_req_out && !dma_tx_req_out && cmd_byte_out == 8'h00;
    endproperty
    a_release: assert property (p_release) else $error("outputs set after reset");
    property p_rx_drop;
        rd && paddr_in == 8'h14 && dma_rx_req_out |-> ##[1:2] !dma_rx_req_out;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx request held");
    property p_tx_drop;
        wr && paddr_in == 8'h14 && dma_tx_req_out |-> ##[1:2] !dma_tx_req_out;
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("tx request held");
    property p_unstop;
        ((rd && !cmd_byte_out[7]) || (wr && cmd_byte_out[7])) && paddr_in == 8'h14
            && card_clk_stop_out
            |-> ##[1:3] !card_clk_stop_out;
    endproperty
    a_unstop: assert property (p_unstop) else $error("card clock still paused");
    property p_cmd_byte;
        wr && paddr_in == 8'h04 && pow_on |=> cmd_byte_out == $past(pwdata_in[7:0]);
    endproperty
    a_cmd_byte: assert property (p_cmd_byte) else $error("command byte wrong");
    c_rx: cover property ($rose(dma_rx_req_out));
    c_tx: cover property ($rose(dma_tx_req_out));
    c_stop: cover property ($rose(card_clk_stop_out));
endmodule
bind chd_top chd_top_monitor #(.DATA_W(DATA_W)) i_monitor (.*);

// [verification/chd_card_model.sv]
// card model: paced card clock, read words out, written words captured
`timescale 1ns/1ns
module chd_card_model (
    input wire logic run_in,
    input wire logic stop_in,
    input wire logic [15:0] dout_in,
    output logic cclk_out,
    output logic [15:0] cdata_out
);
    logic [15:0] sent_q[$];
    logic [15:0] got_q[$];
    initial
    begin
        cclk_out = 1'b0;
        cdata_out = 16'h5A3C;
    end
    // clock only inside frames and frozen while paused; idle data keeps moving
    always #24
    begin
        if (run_in && !stop_in)
            cclk_out = ~cclk_out;
        else if (!run_in)
        begin
            // park low between frames so every frame opens on a rising edge
            cclk_out = 1'b0;
            cdata_out = ~cdata_out;
        end
    end
    always @(posedge cclk_out)
        sent_q.push_back(cdata_out);
    always @(negedge cclk_out)
    begin
        if (run_in)
            got_q.push_back(dout_in);
        cdata_out = cdata_out * 16'h0005 + 16'h3B1D;
    end
endmodule

// [verification/testbench.sv]
// self-checking bench for the card host data path
`timescale 1ns/1ns
module testbench;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic card_clk_in;
    logic [15:0] card_data_in;
    logic [15:0] card_data_out;
    logic card_clk_stop_out;
    logic dma_rx_req_out;
    logic dma_tx_req_out;
    logic [7:0] cmd_byte_out;
    logic run = 1'b0;
    logic [31:0] rd;
    logic err;
    logic [15:0] exp_q[$];
    logic [7:0] cb;
    integer seed = 76671;
    integer error_cnt = 0;
    integer cmp_count = 0;
    integer i;
    integer k;
    always #2 clk_in = ~clk_in;
    chd_top #(.DATA_W(16)) i_dut (.*);
    chd_card_model i_card (.run_in(run), .stop_in(card_clk_stop_out),
        .dout_in(card_data_out), .cclk_out(card_clk_in), .cdata_out(card_data_in));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        chk("pready", 1, pready_out);
        if (pready_out !== 1'b1)
            report_and_stop();
    endtask
    task automatic wait_hi(ref logic s, input integer lim);
        integer n;
        n = 0;
        while (s !== 1'b1 && n < lim)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= lim)
        begin
            error_cnt++;
            $display("mismatch wait expected 1 seen %b", s);
            report_and_stop();
        end
    endtask
    task automatic gap;
        @(posedge clk_in);
        #1;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        apb(1'b0, 8'h68, 0);
        chk("reset_done", 0, rd);
        apb(1'b0, 8'h64, 0);
        chk("soft_reset_bit", 0, rd[1]);
        apb(1'b1, 8'h00, 32'h800);
        apb(1'b0, 8'h68, 0);
        chk("reset_done", 0, rd[0]);
        run <= 1'b1;
        repeat (40) @(posedge clk_in);
        run <= 1'b0;
        apb(1'b0, 8'h68, 0);
        chk("reset_done", 1, rd[0]);
        apb(1'b0, 8'h1C, 0);
        chk("pslverr", 1, err);
        $display("reset test done");
        for (i = 0; i < 16; i++)
        begin
            cb = ($random(seed) & 8'hC8) | ((i % 4) << 4) | (i % 7);
            cb = (i == 0) ? 8'h29 : (i == 1) ? 8'h40 : cb;
            apb(1'b1, 8'h04, {24'h0, cb});
            gap();
            chk("cmd_byte", cb, cmd_byte_out);
        end
        $display("command byte test done");
        i_card.sent_q.delete();
        i_card.got_q.delete();
        apb(1'b1, 8'h08, 32'h0303);
        apb(1'b1, 8'h0C, 8);
        apb(1'b1, 8'h10, 1);
        apb(1'b1, 8'h04, 32'hB1);
        run <= 1'b1;
        wait_hi(dma_tx_req_out, 100);
        chk("clk_stop", 1, card_clk_stop_out);
        for (k = 0; k < 8; k++)
        begin
            if (k % 4 == 0)
                wait_hi(dma_tx_req_out, 2000);
            else
                gap();
            if (k % 4 != 0)
                chk("tx_req", 0, dma_tx_req_out);
            exp_q.push_back($random(seed));
            apb(1'b1, 8'h14, {16'h0, exp_q[k]});
        end
        for (k = 0; k < 3000 && i_card.got_q.size() < 8; k++)
            gap();
        for (k = 0; k < 8; k++)
            chk("tx_word", exp_q[k], i_card.got_q[k]);
        run <= 1'b0;
        $display("write test done");
        gap();
        i_card.sent_q.delete();
        apb(1'b1, 8'h0C, 36);
        apb(1'b1, 8'h10, 1);
        apb(1'b1, 8'h04, 32'h31);
        run <= 1'b1;
        wait_hi(card_clk_stop_out, 3000);
        apb(1'b0, 8'h18, 0);
        chk("fifo_level", 32, rd[7:2]);
        for (k = 0; k < 36; k++)
        begin
            if (k % 4 == 0)
                wait_hi(dma_rx_req_out, 2000);
            else
                gap();
            if (k % 4 != 0)
                chk("rx_req", 0, dma_rx_req_out);
            apb(1'b0, 8'h14, 0);
            chk("rx_word", {16'h0, i_card.sent_q.pop_front()}, rd);
        end
        run <= 1'b0;
        $display("read test done");
        apb(1'b1, 8'h60, 32'h8);
        apb(1'b0, 8'h60, 0);
        chk("stop_flag", 0, rd[3]);
        exp_q.push_back($random(seed));
        apb(1'b1, 8'h14, {16'h0, exp_q[8]});
        apb(1'b0, 8'h18, 0);
        chk("fifo_level_flag", 0, rd[0]);
        apb(1'b1, 8'h60, 32'h4);
        apb(1'b0, 8'h18, 0);
        chk("fifo_level_flag", 1, rd[0]);
        apb(1'b0, 8'h14, 0);
        chk("saved_word", {16'h0, exp_q[8]}, rd);
        apb(1'b0, 8'h18, 0);
        chk("fifo_level_flag", 0, rd[0]);
        apb(1'b1, 8'h60, 32'h2);
        apb(1'b0, 8'h60, 0);
        chk("resume_flag", 32'h2, rd);
        $display("suspend test done");
        apb(1'b1, 8'h64, 32'h2);
        repeat (3) gap();
        chk("cmd_byte", 0, cmd_byte_out);
        apb(1'b0, 8'h68, 0);
        chk("reset_done", 0, rd[0]);
        apb(1'b0, 8'h00, 0);
        chk("power_bit", 0, rd[11]);
        $display("soft reset test done");
        report_and_stop();
    end
endmodule
